// ==== bench/link_primitive_mailbox_test.sv ====
// self-checking bench for the primitive mailbox and its option registers
// assumes lpm_engine_model answers commands; host steps start on falling edges
`timescale 1ns/1ps
`default_nettype none
module link_primitive_mailbox_test import lpm_pkg::*;;
   logic sys_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic reg_addr_port_i = 1'b0;
   logic reg_wr_i = 1'b0;
   logic reg_rd_i = 1'b0;
   logic rx_eof_i = 1'b0;
   logic stall = 1'b0;
   logic [15:0] reg_wdata_i = 16'h0000;
   logic [5:0] rx_fifo_words_i = 6'h00;
   logic [5:0] tx_fifo_room_i = 6'h00;
   logic [15:0] reg_rdata_o, d;
   logic [23:0] init_block_pointer_o;
   logic [1:0] burst_limit_o;
   logic [7:0] taken;
   logic cmd_valid_o, cmd_ready_i, ind_valid_i, stopped_o, tx_mark_idle_o, tx_flags_o;
   logic dma_halt_o, ring_reset_o, transparent_o, primitive_interrupt_flag_o;
   logic ui_frame_enable_o, xid_frame_enable_o, filter_bypass_o, alt_protocol_enable_o;
   logic rx_dma_go_o, tx_dma_go_o, control_byte_swap_o, data_byte_swap_o;
   logic strobe_assert_high_o, byte_pin_select_o;
   cmd_t cmd_o, last_cmd;
   ind_t ind_i;
   int n_mismatch = 0;
   int samples_checked = 0;
   int n_ring = 0;
   int n_primitive_interrupt_flag = 0;
   int exp_taken = 0;

   link_primitive_mailbox uut (.sys_clk_i, .rst_i, .reg_addr_port_i, .reg_wr_i, .reg_rd_i,
      .reg_wdata_i, .reg_rdata_o, .cmd_valid_o, .cmd_o, .cmd_ready_i, .ind_valid_i, .ind_i,
      .stopped_o, .tx_mark_idle_o, .tx_flags_o, .dma_halt_o, .ring_reset_o, .transparent_o,
      .primitive_interrupt_flag_o, .ui_frame_enable_o, .xid_frame_enable_o, .filter_bypass_o,
      .alt_protocol_enable_o, .init_block_pointer_o, .rx_fifo_words_i, .rx_eof_i,
      .tx_fifo_room_i, .rx_dma_go_o, .tx_dma_go_o, .control_byte_swap_o, .data_byte_swap_o,
      .burst_limit_o, .strobe_assert_high_o, .byte_pin_select_o);
   lpm_engine_model em (.sys_clk_i, .rst_i, .cmd_valid_i(cmd_valid_o), .cmd_i(cmd_o),
      .stall_i(stall), .cmd_ready_o(cmd_ready_i), .last_cmd_o(last_cmd), .taken_o(taken),
      .ind_valid_o(ind_valid_i), .ind_o(ind_i));

   initial begin
      forever #20 sys_clk_i = ~sys_clk_i;
   end
   // pulses are registered, so the falling edge sees each one exactly once
   always @(negedge sys_clk_i) begin
      if (ring_reset_o === 1'b1) n_ring++;
      if (primitive_interrupt_flag_o === 1'b1) n_primitive_interrupt_flag++;
   end

   task chk(input logic [23:0] got, input logic [23:0] exp, input string m);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   task acc(input logic a, input logic w, input logic r, input logic [15:0] v);
      @(negedge sys_clk_i);
      reg_addr_port_i = a;
      reg_wr_i = w;
      reg_rd_i = r;
      reg_wdata_i = v;
   endtask
   task wr(input logic [2:0] s, input logic [15:0] v);
      acc(1'b1, 1'b1, 1'b0, {12'h000, s, 1'b0});
      acc(1'b0, 1'b1, 1'b0, v);
      acc(1'b0, 1'b0, 1'b0, v);
   endtask
   task rd(input logic [2:0] s);
      acc(1'b1, 1'b1, 1'b0, {12'h000, s, 1'b0});
      acc(1'b0, 1'b0, 1'b1, 16'h0000);
      acc(1'b0, 1'b0, 1'b0, 16'h0000);
      d = reg_rdata_o;
   endtask
   task cmd(input logic [3:0] c);
      wr(SEL_PRIMITIVE, {4'h4, c, 8'h00});
      repeat (4) @(negedge sys_clk_i);
   endtask
   // issue a command and judge acceptance; a refused one is cleared again
   task issue(input logic [3:0] c, input logic e);
      cmd(c);
      rd(SEL_PRIMITIVE);
      chk(d[15:14], {e, 1'b0}, "error and available flags");
      if (!e) exp_taken++;
      chk(taken, 24'(exp_taken), "commands reaching the engine");
      if (e) wr(SEL_PRIMITIVE, 16'h8000);
   endtask
   task lv(input logic [5:0] w, input logic [5:0] r, input logic e);
      @(negedge sys_clk_i);
      rx_fifo_words_i = w;
      tx_fifo_room_i = r;
      rx_eof_i = e;
      #1;
   endtask

   task t_reset;
      for (int i = 1; i <= 5; i++) begin
         rd(3'(i));
         chk(d, 16'h0000, "reset value");
      end
      chk({stopped_o, tx_flags_o, cmd_valid_o}, 3'b100, "reset phase");
      wr(3'h5, 16'hffff);
      rd(3'h5);
      chk(d, 16'h0000, "unmapped select");
      $display("test reset done");
   endtask
   task t_start;
      issue(CMD_START, 1'b0);
      chk({stopped_o, tx_flags_o, last_cmd.code}, {2'b01, CMD_START}, "start");
      chk({n_ring[7:0], n_primitive_interrupt_flag[7:0]}, 16'h0101, "ring reset and interrupt");
      cmd(CMD_START);
      rd(SEL_PRIMITIVE);
      chk(d[15:14], 2'b10, "second start refused");
      chk({taken, stopped_o}, {8'h01, 1'b0}, "state kept");
      wr(SEL_PRIMITIVE, 16'h0000);
      rd(SEL_PRIMITIVE);
      chk(d[15], 1'b1, "write zero to error");
      wr(SEL_PRIMITIVE, 16'h8000);
      rd(SEL_PRIMITIVE);
      chk(d[15], 1'b0, "write one to error");
      exp_taken = 1;
      $display("test start done");
   endtask
   task t_config;
      wr(SEL_FRAME_OPT, 16'h0fa5);
      wr(SEL_INIT_LOW, 16'h1234);
      wr(SEL_BUS_CFG, 16'h0125);
      rd(SEL_FRAME_OPT);
      chk(d, 16'h0fa5, "frame options");
      rd(SEL_BUS_CFG);
      chk(d, 16'h0125, "bus config");
      chk(init_block_pointer_o, 24'ha51234, "pointer");
      chk({alt_protocol_enable_o, ui_frame_enable_o, xid_frame_enable_o, filter_bypass_o}, 4'b1110,
         "enables");
      chk({control_byte_swap_o, data_byte_swap_o, burst_limit_o, strobe_assert_high_o,
         byte_pin_select_o}, 6'b110011, "bus outputs");
      lv(6'h08, 6'h08, 1'b0);
      chk({rx_dma_go_o, tx_dma_go_o}, 2'b00, "below nine");
      lv(6'h09, 6'h09, 1'b0);
      chk({rx_dma_go_o, tx_dma_go_o}, 2'b11, "at nine");
      lv(6'h00, 6'h00, 1'b1);
      chk(rx_dma_go_o, 1'b1, "end of frame");
      wr(SEL_BUS_CFG, 16'h021a);
      chk({control_byte_swap_o, data_byte_swap_o, burst_limit_o, strobe_assert_high_o,
         byte_pin_select_o}, 6'b001100, "bus outputs 2");
      lv(6'h10, 6'h10, 1'b0);
      chk({rx_dma_go_o, tx_dma_go_o}, 2'b00, "below seventeen");
      lv(6'h11, 6'h11, 1'b0);
      chk({rx_dma_go_o, tx_dma_go_o}, 2'b11, "at seventeen");
      $display("test config done");
   endtask
   task t_ind;
      int p;
      p = n_primitive_interrupt_flag;
      @(negedge sys_clk_i);
      em.post(IND_CONN, 2'h0);
      rd(SEL_PRIMITIVE);
      chk({d[7:0], 8'(n_primitive_interrupt_flag - p)}, 16'h4601, "indication");
      em.post(IND_XID, 2'h1);
      rd(SEL_PRIMITIVE);
      chk(d[7:0], 8'hc6, "lost keeps value");
      wr(SEL_PRIMITIVE, 16'h0040);
      rd(SEL_PRIMITIVE);
      chk(d[7:6], 2'b00, "lost clears with available");
      issue(CMD_CONN_RSP, 1'b0);
      em.post(IND_ERROR, 2'h1);
      rd(SEL_PRIMITIVE);
      chk(d[6:0], 7'h54, "error indication");
      wr(SEL_PRIMITIVE, 16'h0040);
      issue(CMD_RST_REQ, 1'b0);
      issue(CMD_RST_RSP, 1'b1);
      em.post(IND_RESET, 2'h0);
      wr(SEL_PRIMITIVE, 16'h0040);
      issue(CMD_RST_RSP, 1'b0);
      em.post(IND_DISC, 2'h3);
      rd(SEL_PRIMITIVE);
      chk(d[6:0], 7'h7e, "disconnect indication");
      wr(SEL_PRIMITIVE, 16'h0040);
      issue(CMD_DISC_REQ, 1'b0);
      chk(last_cmd, {CMD_DISC_REQ, 1'b1}, "dm with final clear");
      issue(CMD_TEST_RSP, 1'b1);
      issue(CMD_TEST_REQ, 1'b0);
      $display("test indication done");
   endtask
   task t_trans;
      issue(CMD_TRANS, 1'b0);
      chk({transparent_o, filter_bypass_o}, 2'b11, "transparent");
      issue(CMD_CONN_REQ, 1'b1);
      chk(transparent_o, 1'b1, "still transparent");
      issue(CMD_STOP, 1'b0);
      chk({stopped_o, tx_mark_idle_o, dma_halt_o, tx_flags_o, transparent_o, rx_dma_go_o,
         tx_dma_go_o}, 7'b1110000, "stopped");
      $display("test transparent done");
   endtask
   task t_fill;
      @(negedge sys_clk_i);
      stall = 1'b1;
      for (int i = 0; i < 9; i++) cmd(CMD_INIT);
      rd(SEL_PRIMITIVE);
      chk({d[14], cmd_valid_o, cmd_o.code}, {2'b11, CMD_INIT}, "full fifo stalls");
      @(negedge sys_clk_i);
      stall = 1'b0;
      repeat (20) @(negedge sys_clk_i);
      rd(SEL_PRIMITIVE);
      exp_taken += 9;
      chk({d[15:14], taken}, {2'b00, 8'(exp_taken)}, "fifo drained");
      issue(CMD_STATUS, 1'b0);
      $display("test fill done");
   endtask

   task end_sim;
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   initial begin
      repeat (16) @(negedge sys_clk_i);
      rst_i = 1'b0;
      t_reset();
      t_start();
      t_config();
      t_ind();
      t_trans();
      t_fill();
      end_sim();
   end
   // the tests need a few hundred cycles; this is a generous margin
   initial begin
      repeat (20000) @(posedge sys_clk_i);
      n_mismatch++;
      $display("CHECK FAILED at %0t: watchdog", $time);
      end_sim();
   end
endmodule
`default_nettype wire

// ==== bench/lpm_engine_model.sv ====
// behavioural link engine on the command and indication side of the mailbox
// assumes the bench calls post() just after a falling edge and drives stall_i
`timescale 1ns/1ps
`default_nettype none
module lpm_engine_model
   import lpm_pkg::*;
(
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_i,
   // commands from the mailbox
   input wire logic cmd_valid_i,
   input wire cmd_t cmd_i,
   input wire logic stall_i,
   output logic cmd_ready_o,
   output cmd_t last_cmd_o,
   output logic [7:0] taken_o,
   // indications toward the mailbox
   output logic ind_valid_o,
   output ind_t ind_o
);
   // a stall holds ready low so the mailbox fifo backs up
   assign cmd_ready_o = !stall_i && !rst_i;
   always @(posedge sys_clk_i) begin
      if (rst_i) begin
         taken_o <= 8'h00;
         last_cmd_o <= '0;
      end else if (cmd_valid_i && cmd_ready_o) begin
         taken_o <= taken_o + 8'h01;
         last_cmd_o <= cmd_i;
      end
   end
   initial begin
      ind_valid_o = 1'b0;
      ind_o = '0;
   end
   task post(input logic [3:0] code, input logic [1:0] parm);
      ind_valid_o = 1'b1;
      ind_o = {code, parm};
      @(negedge sys_clk_i);
      ind_valid_o = 1'b0;
      // payload is not held past the pulse
      ind_o = ~ind_o;
   endtask
endmodule
`default_nettype wire

// ==== rtl/link_primitive_mailbox.sv ====
// command fifo and the host-facing primitive mailbox with link options
// assumes the link engine runs on sys_clk_i and the host uses the port pair
`timescale 1ns/1ps
`default_nettype none

module lpm_fifo #(
   parameter int WIDTH = 5,
   parameter int DEPTH = 8
) (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   // fill side
   input wire logic in_valid_i,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic in_ready_o,
   // drain side
   output logic out_valid_o,
   output logic [WIDTH-1:0] out_data_o,
   input wire logic out_ready_i
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [AW-1:0] wr_ptr_ff, nxt_wr_ptr, rd_ptr_ff, nxt_rd_ptr;
   logic [AW:0] count_ff, nxt_count;
   logic push, pop;

   always_comb begin
      push = in_valid_i && in_ready_o;
      pop = out_valid_o && out_ready_i;
      nxt_wr_ptr = push ? AW'(wr_ptr_ff + 1'b1) : wr_ptr_ff;
      nxt_rd_ptr = pop ? AW'(rd_ptr_ff + 1'b1) : rd_ptr_ff;
      nxt_count = (AW+1)'(count_ff + (AW+1)'(push) - (AW+1)'(pop));
   end

   assign in_ready_o = count_ff != (AW+1)'(DEPTH);
   assign out_valid_o = count_ff != '0;
   assign out_data_o = mem_ff[rd_ptr_ff];

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         count_ff <= '0;
      end else begin
         wr_ptr_ff <= nxt_wr_ptr;
         rd_ptr_ff <= nxt_rd_ptr;
         count_ff <= nxt_count;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (push) begin
         mem_ff[wr_ptr_ff] <= in_data_i;
      end
   end
endmodule

module link_primitive_mailbox
   import lpm_pkg::*;
(
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_i,
   // host register port pair
   input wire logic reg_addr_port_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [15:0] reg_wdata_i,
   output logic [15:0] reg_rdata_o,
   // commands toward the link engine
   output logic cmd_valid_o,
   output cmd_t cmd_o,
   input wire logic cmd_ready_i,
   // indications from the link engine
   input wire logic ind_valid_i,
   input wire ind_t ind_i,
   // link state
   output logic stopped_o,
   output logic tx_mark_idle_o,
   output logic tx_flags_o,
   output logic dma_halt_o,
   output logic ring_reset_o,
   output logic transparent_o,
   output logic primitive_interrupt_flag_o,
   // frame recognition
   output logic ui_frame_enable_o,
   output logic xid_frame_enable_o,
   output logic filter_bypass_o,
   output logic alt_protocol_enable_o,
   output logic [23:0] init_block_pointer_o,
   // bus master configuration
   input wire logic [5:0] rx_fifo_words_i,
   input wire logic rx_eof_i,
   input wire logic [5:0] tx_fifo_room_i,
   output logic rx_dma_go_o,
   output logic tx_dma_go_o,
   output logic control_byte_swap_o,
   output logic data_byte_swap_o,
   output logic [1:0] burst_limit_o,
   output logic strobe_assert_high_o,
   output logic byte_pin_select_o
);
   // register state
   logic [2:0] sel_ff, nxt_sel;
   logic user_command_error_ff, nxt_user_command_error, uav_ff, nxt_uav, lost_ff, nxt_lost, iav_ff, nxt_iav;
   logic [3:0] ucode_ff, nxt_ucode;
   ind_t ind_ff, nxt_ind;
   logic [11:0] opt_ff, nxt_opt;
   logic [15:0] ptr_low_ff, nxt_ptr_low;
   logic [9:0] bus_ff, nxt_bus;
   logic [15:0] rdata_ff, nxt_rdata;
   // link state
   phase_t phase_ff, nxt_phase;
   logic init_seen_ff, nxt_init_seen, conn_seen_ff, nxt_conn_seen;
   logic rst_seen_ff, nxt_rst_seen, xid_seen_ff, nxt_xid_seen;
   logic test_seen_ff, nxt_test_seen, ring_reset_ff, nxt_ring_reset;
   logic primitive_interrupt_flag_ff, nxt_primitive_interrupt_flag;
   // command path
   logic fifo_in_ready, take_cmd, cmd_ok, data_wr, iav_clr;
   cmd_t fifo_in;
   logic [15:0] prim_word;
   logic [5:0] wm_words;

   always_comb begin
      prim_word = {user_command_error_ff, uav_ff, 2'b00, ucode_ff, lost_ff, iav_ff, ind_ff.parm, ind_ff.code};
      data_wr = reg_wr_i && !reg_addr_port_i;
      // a pending command waits while the fifo is full
      take_cmd = uav_ff && fifo_in_ready;
      case (ucode_ff)
         CMD_STOP: cmd_ok = 1'b1;
         CMD_START: cmd_ok = phase_ff == PH_STOPPED;
         CMD_INIT: cmd_ok = phase_ff == PH_STOPPED || phase_ff == PH_DISC;
         CMD_TRANS: cmd_ok = phase_ff == PH_DISC;
         CMD_STATUS: cmd_ok = init_seen_ff;
         CMD_CONN_REQ: cmd_ok = phase_ff == PH_DISC;
         CMD_CONN_RSP: cmd_ok = phase_ff == PH_DISC && conn_seen_ff;
         CMD_RST_REQ: cmd_ok = phase_ff == PH_INFO;
         CMD_RST_RSP: cmd_ok = phase_ff == PH_INFO && rst_seen_ff;
         CMD_XID_REQ, CMD_TEST_REQ: cmd_ok = phase_ff == PH_DISC || phase_ff == PH_INFO;
         CMD_XID_RSP: cmd_ok = phase_ff != PH_STOPPED && phase_ff != PH_TRANSP && xid_seen_ff;
         CMD_TEST_RSP: cmd_ok = phase_ff != PH_STOPPED && phase_ff != PH_TRANSP && test_seen_ff;
         CMD_DISC_REQ: cmd_ok = phase_ff == PH_DISC || phase_ff == PH_INFO;
         default: cmd_ok = 1'b0;
      endcase
      fifo_in.code = ucode_ff;
      fifo_in.dm_final_clear = ucode_ff == CMD_DISC_REQ && phase_ff == PH_DISC;
   end

   lpm_fifo #(
      .WIDTH($bits(cmd_t)),
      .DEPTH(CMD_FIFO_DEPTH)
   ) u_cmd_fifo (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .in_valid_i(take_cmd && cmd_ok),
      .in_data_i(fifo_in),
      .in_ready_o(fifo_in_ready),
      .out_valid_o(cmd_valid_o),
      .out_data_o(cmd_o),
      .out_ready_i(cmd_ready_i)
   );

   // register file
   always_comb begin
      nxt_sel = sel_ff;
      nxt_ucode = ucode_ff;
      nxt_opt = opt_ff;
      nxt_ptr_low = ptr_low_ff;
      nxt_bus = bus_ff;
      nxt_ind = ind_ff;
      nxt_rdata = rdata_ff;
      iav_clr = data_wr && sel_ff == SEL_PRIMITIVE && reg_wdata_i[BIT_IAV];
      if (reg_wr_i && reg_addr_port_i) begin
         nxt_sel = reg_wdata_i[3:1];
      end
      if (data_wr) begin
         case (sel_ff)
            SEL_PRIMITIVE: nxt_ucode = reg_wdata_i[UCODE_LSB +: 4];
            SEL_FRAME_OPT: nxt_opt = reg_wdata_i[11:0];
            SEL_INIT_LOW: nxt_ptr_low = reg_wdata_i;
            SEL_BUS_CFG: nxt_bus = {reg_wdata_i[9:8], 2'b00, reg_wdata_i[5:0]};
            default: nxt_sel = nxt_sel;
         endcase
      end
      // user_command_error and iav: a hardware set in the same cycle beats the host clear
      nxt_user_command_error = (user_command_error_ff && !(data_wr && sel_ff == SEL_PRIMITIVE && reg_wdata_i[BIT_USER_COMMAND_ERROR]))
                 || (take_cmd && !cmd_ok);
      nxt_uav = (uav_ff && !take_cmd)
                || (data_wr && sel_ff == SEL_PRIMITIVE && reg_wdata_i[BIT_UAV]);
      nxt_iav = (iav_ff && !iav_clr) || ind_valid_i;
      // a new indication overwrites only a slot the host has released
      nxt_lost = ind_valid_i && iav_ff && !iav_clr ? 1'b1 : (lost_ff && nxt_iav);
      if (ind_valid_i && !(iav_ff && !iav_clr)) begin
         nxt_ind = ind_i;
      end
      nxt_primitive_interrupt_flag = take_cmd || (ind_valid_i && !(iav_ff && !iav_clr));
      if (reg_rd_i) begin
         if (reg_addr_port_i) begin
            nxt_rdata = {12'h000, sel_ff, 1'b0};
         end else begin
            case (sel_ff)
               SEL_PRIMITIVE: nxt_rdata = prim_word;
               SEL_FRAME_OPT: nxt_rdata = {4'h0, opt_ff};
               SEL_INIT_LOW: nxt_rdata = ptr_low_ff;
               SEL_BUS_CFG: nxt_rdata = {6'h00, bus_ff};
               default: nxt_rdata = 16'h0000;
            endcase
         end
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         sel_ff <= 3'h0;
         user_command_error_ff <= 1'b0;
         uav_ff <= 1'b0;
         ucode_ff <= 4'h0;
         lost_ff <= 1'b0;
         iav_ff <= 1'b0;
         ind_ff <= '0;
         opt_ff <= 12'h000;
         ptr_low_ff <= 16'h0000;
         bus_ff <= 10'h000;
         rdata_ff <= 16'h0000;
         primitive_interrupt_flag_ff <= 1'b0;
      end else begin
         sel_ff <= nxt_sel;
         user_command_error_ff <= nxt_user_command_error;
         uav_ff <= nxt_uav;
         ucode_ff <= nxt_ucode;
         lost_ff <= nxt_lost;
         iav_ff <= nxt_iav;
         ind_ff <= nxt_ind;
         opt_ff <= nxt_opt;
         ptr_low_ff <= nxt_ptr_low;
         bus_ff <= nxt_bus;
         rdata_ff <= nxt_rdata;
         primitive_interrupt_flag_ff <= nxt_primitive_interrupt_flag;
      end
   end

   // link phase tracking
   always_comb begin
      nxt_phase = phase_ff;
      nxt_init_seen = init_seen_ff;
      nxt_conn_seen = conn_seen_ff;
      nxt_rst_seen = rst_seen_ff;
      nxt_xid_seen = xid_seen_ff;
      nxt_test_seen = test_seen_ff;
      nxt_ring_reset = 1'b0;
      if (ind_valid_i && phase_ff != PH_STOPPED && phase_ff != PH_TRANSP) begin
         case (ind_i.code)
            IND_CONN: nxt_conn_seen = 1'b1;
            IND_CONN_CNF: nxt_phase = PH_INFO;
            IND_RESET: nxt_rst_seen = 1'b1;
            IND_XID: nxt_xid_seen = 1'b1;
            IND_TEST: nxt_test_seen = 1'b1;
            IND_DISC: begin
               nxt_phase = PH_DISC;
               nxt_conn_seen = 1'b0;
               nxt_rst_seen = 1'b0;
            end
            default: nxt_phase = nxt_phase;
         endcase
      end
      // a rejected command touches none of this state
      if (take_cmd && cmd_ok) begin
         case (ucode_ff)
            CMD_STOP: begin
               nxt_phase = PH_STOPPED;
               nxt_conn_seen = 1'b0;
               nxt_rst_seen = 1'b0;
               nxt_xid_seen = 1'b0;
               nxt_test_seen = 1'b0;
            end
            CMD_START: begin
               nxt_phase = PH_DISC;
               nxt_ring_reset = 1'b1;
            end
            CMD_INIT: nxt_init_seen = 1'b1;
            CMD_TRANS: nxt_phase = PH_TRANSP;
            CMD_CONN_RSP: begin
               nxt_phase = PH_INFO;
               nxt_conn_seen = 1'b0;
            end
            CMD_RST_RSP: nxt_rst_seen = 1'b0;
            CMD_XID_RSP: nxt_xid_seen = 1'b0;
            CMD_TEST_RSP: nxt_test_seen = 1'b0;
            default: nxt_phase = nxt_phase;
         endcase
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         phase_ff <= PH_STOPPED;
         init_seen_ff <= 1'b0;
         conn_seen_ff <= 1'b0;
         rst_seen_ff <= 1'b0;
         xid_seen_ff <= 1'b0;
         test_seen_ff <= 1'b0;
         ring_reset_ff <= 1'b0;
      end else begin
         phase_ff <= nxt_phase;
         init_seen_ff <= nxt_init_seen;
         conn_seen_ff <= nxt_conn_seen;
         rst_seen_ff <= nxt_rst_seen;
         xid_seen_ff <= nxt_xid_seen;
         test_seen_ff <= nxt_test_seen;
         ring_reset_ff <= nxt_ring_reset;
      end
   end

   // outputs
   assign reg_rdata_o = rdata_ff;
   assign stopped_o = phase_ff == PH_STOPPED;
   assign tx_mark_idle_o = phase_ff == PH_STOPPED;
   assign dma_halt_o = phase_ff == PH_STOPPED;
   assign tx_flags_o = phase_ff != PH_STOPPED;
   assign ring_reset_o = ring_reset_ff;
   assign transparent_o = phase_ff == PH_TRANSP;
   assign primitive_interrupt_flag_o = primitive_interrupt_flag_ff;
   assign ui_frame_enable_o = opt_ff[BIT_UIE];
   assign xid_frame_enable_o = opt_ff[BIT_XID_FRAME_ENABLE];
   assign filter_bypass_o = opt_ff[BIT_BYPASS] && phase_ff == PH_TRANSP;
   assign alt_protocol_enable_o = opt_ff[BIT_ALT];
   assign init_block_pointer_o = {opt_ff[7:0], ptr_low_ff};
   assign wm_words = 6'(WM_BASE + WM_STEP * {4'h0, bus_ff[FWM_LSB +: 2]});
   assign rx_dma_go_o = !dma_halt_o && (rx_fifo_words_i >= wm_words || rx_eof_i);
   assign tx_dma_go_o = !dma_halt_o && tx_fifo_room_i >= wm_words;
   assign control_byte_swap_o = bus_ff[BIT_CSWAP];
   assign data_byte_swap_o = bus_ff[BIT_DSWAP];
   assign burst_limit_o = bus_ff[BURST_LSB +: 2];
   assign strobe_assert_high_o = !bus_ff[BIT_STROBE];
   assign byte_pin_select_o = bus_ff[BIT_BYTEPIN];

   // checks
   AST_USER_COMMAND_ERROR_ON_REJECT: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      take_cmd && !cmd_ok |=> user_command_error_ff && !uav_ff) else $error("reject without error");
   AST_UAV_CLEARS: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      take_cmd && !data_wr |=> !uav_ff) else $error("available not cleared");
   AST_STOP_ENTERS: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      take_cmd && ucode_ff == CMD_STOP |=> stopped_o && tx_mark_idle_o && !rx_dma_go_o)
      else $error("stop not entered");
   AST_START_ONLY_STOPPED: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      take_cmd && ucode_ff == CMD_START && !stopped_o |=> user_command_error_ff)
      else $error("start accepted outside stop");
   AST_START_RING_RESET: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      take_cmd && ucode_ff == CMD_START && stopped_o |=> ring_reset_o ##1 !ring_reset_o)
      else $error("ring reset not one pulse");
   AST_TRANSP_HOLDS: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      transparent_o && !(take_cmd && ucode_ff == CMD_STOP) |=> transparent_o)
      else $error("transparent left without stop");
   AST_LOST_SET: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      ind_valid_i && iav_ff && !iav_clr |=> lost_ff && $stable(ind_ff))
      else $error("lost flag missing");
   AST_IAV_SET: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      ind_valid_i |=> iav_ff) else $error("available not set");
   AST_LOST_FOLLOWS: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      lost_ff |-> iav_ff) else $error("lost without available");
   AST_DISC_PHASE: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      ind_valid_i && ind_i.code == IND_DISC && phase_ff == PH_INFO && !take_cmd
      |=> phase_ff == PH_DISC) else $error("disconnect not taken");
   AST_PRIMITIVE_INTERRUPT_FLAG: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      take_cmd |=> primitive_interrupt_flag_o) else $error("no primitive interrupt");
   AST_WM: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      bus_ff[FWM_LSB +: 2] == 2'b11 |-> wm_words == 6'd25) else $error("watermark wrong");
endmodule

`default_nettype wire

// ==== rtl/lpm_pkg.sv ====
// constants, codes and carrier types for the link primitive mailbox
// assumes a single 16-bit address/data port pair and a same-clock link engine
// Function
// - user error set on conflict, write-one clears
// - host sets command available; device clears
// - code 0 stops link, marks, halts dma
// - code 1 only when stopped: disconnected, flags
// - code 2 fetches init; code 4 needs init
// - code 3 transparent, left only by stop
// - codes 6 and 7 need disconnected phase
// - code 8 needs link; 9 needs reset indication
// - xid/test requests, responses after matching indication
// - code 14 not stopped; DM if disconnected
// - indication lost when available still set
// - indication available set per new code
// - indication parameter carries the cause
// - indication codes; 14 means disconnected phase
// - ui and xid frame enables, read/write
// - filter bypass only in transparent operation
// - 24-bit init pointer over two registers
// - watermark selects 1, 9, 17, 25 words
// - separate swap bits for control and data
// - burst field limits transfers per tenure
// - strobe polarity sets address strobe level
// - byte pin select redefines mask/hold pins
// - primitive interrupt on every exchange update; none is raised when an indication only sets lost
package lpm_pkg;
   // register select values held in the address port, bits 3:1
   localparam logic [2:0] SEL_PRIMITIVE = 3'h1;
   localparam logic [2:0] SEL_FRAME_OPT = 3'h2;
   localparam logic [2:0] SEL_INIT_LOW = 3'h3;
   localparam logic [2:0] SEL_BUS_CFG = 3'h4;
   localparam logic [3:0] ADDR_PORT_MASK = 4'he;
   // primitive_exchange field positions
   localparam int BIT_USER_COMMAND_ERROR = 15;
   localparam int BIT_UAV = 14;
   localparam int UCODE_LSB = 8;
   localparam int BIT_LOST = 7;
   localparam int BIT_IAV = 6;
   localparam int PARM_LSB = 4;
   // frame_options_init_addr_high field positions
   localparam int BIT_ALT = 11;
   localparam int BIT_BYPASS = 10;
   localparam int BIT_UIE = 9;
   localparam int BIT_XID_FRAME_ENABLE = 8;
   // bus_master_config field positions
   localparam int FWM_LSB = 8;
   localparam int BIT_CSWAP = 5;
   localparam int BURST_LSB = 3;
   localparam int BIT_DSWAP = 2;
   localparam int BIT_STROBE = 1;
   localparam int BIT_BYTEPIN = 0;
   // watermark: words = base + step * code
   localparam logic [5:0] WM_BASE = 6'h01;
   localparam logic [5:0] WM_STEP = 6'h08;
   // command and indication codes
   localparam logic [3:0] CMD_STOP = 4'h0;
   localparam logic [3:0] CMD_START = 4'h1;
   localparam logic [3:0] CMD_INIT = 4'h2;
   localparam logic [3:0] CMD_TRANS = 4'h3;
   localparam logic [3:0] CMD_STATUS = 4'h4;
   localparam logic [3:0] CMD_CONN_REQ = 4'h6;
   localparam logic [3:0] CMD_CONN_RSP = 4'h7;
   localparam logic [3:0] CMD_RST_REQ = 4'h8;
   localparam logic [3:0] CMD_RST_RSP = 4'h9;
   localparam logic [3:0] CMD_XID_REQ = 4'ha;
   localparam logic [3:0] CMD_XID_RSP = 4'hb;
   localparam logic [3:0] CMD_TEST_REQ = 4'hc;
   localparam logic [3:0] CMD_TEST_RSP = 4'hd;
   localparam logic [3:0] CMD_DISC_REQ = 4'he;
   localparam logic [3:0] IND_INIT_DONE = 4'h2;
   localparam logic [3:0] IND_ERROR = 4'h4;
   localparam logic [3:0] IND_CONN = 4'h6;
   localparam logic [3:0] IND_CONN_CNF = 4'h7;
   localparam logic [3:0] IND_RESET = 4'h8;
   localparam logic [3:0] IND_XID = 4'ha;
   localparam logic [3:0] IND_TEST = 4'hc;
   localparam logic [3:0] IND_DISC = 4'he;
   localparam int CMD_FIFO_DEPTH = 8;

   typedef enum logic [1:0] {
      PH_STOPPED = 2'b00,
      PH_DISC = 2'b01,
      PH_INFO = 2'b10,
      PH_TRANSP = 2'b11
   } phase_t;

   // command handed to the link engine; dm_final_clear asks for DM with F clear
   typedef struct packed {
      logic [3:0] code;
      logic dm_final_clear;
   } cmd_t;

   // indication posted by the link engine
   typedef struct packed {
      logic [3:0] code;
      logic [1:0] parm;
   } ind_t;
endpackage
